// ### debug_command_gate.sv
// command acceptance gate of the debug unit
// ----------------------------------------
// Notes on behaviour
// - each received byte is a debugger command
// - outside debug mode only a subset accepted
// - in debug mode all five defined commands accepted
// - read protection disables memory-reading commands
// - 00h, 02h always; 03h debug only
// - 04h/05h anytime; protected 04h keeps flag
// - return to looping breakpoint sets flag
// - looping on breakpoint leaves command acceptance unchanged
// - opcode 00h decodes as breakpoint instruction
// ----------------------------------------
module debug_command_gate #(
   parameter int NUM_PROTECTED = 8 // reader codes just above the command table
) (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic cmd_valid, // command byte strobe from the pin interface
   input wire logic [7:0] cmd_byte, // received command byte
   input wire logic [7:0] cmd_data, // data byte for a control write
   input wire logic read_protect_option, // read protect option programmed
   input wire logic [7:0] fetch_opcode, // opcode being decoded by the core
   input wire logic fetch_valid, // fetch_opcode is valid this cycle
   input wire logic irq_return, // core returns from interrupt service
   output logic cmd_accept, // pulse: command honoured
   output logic cmd_reject, // pulse: command discarded
   output logic [7:0] accepted_cmd, // last honoured command byte
   output logic [7:0] control_reg, // debug control byte
   output logic debug_mode_flag, // debug mode active
   output logic breakpoint_instruction, // current fetch is a breakpoint
   output logic breakpoint_loop // core looping on a breakpoint
);
   import debug_gate_pkg::*;

   // the gate judges bytes and carries out the control write itself: framing on the pin and the work of the
   // other commands belong to the pin interface and the command handlers

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   // every code the unit knows, whatever the mode
   function automatic logic is_defined(input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      if (code == CMD_READ_REVISION) begin
         hit = 1'b1;
      end else if (code == CMD_READ_STATUS) begin
         hit = 1'b1;
      end else if (code == CMD_READ_RUNTIME) begin
         hit = 1'b1;
      end else if (code == CMD_WRITE_CONTROL) begin
         hit = 1'b1;
      end else if (code == CMD_READ_CONTROL) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // the subset honoured outside debug mode; the runtime counter is left out
   function automatic logic is_normal_subset(input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      if (code == CMD_READ_REVISION) begin
         hit = 1'b1;
      end else if (code == CMD_READ_STATUS) begin
         hit = 1'b1;
      end else if (code == CMD_WRITE_CONTROL) begin
         hit = 1'b1;
      end else if (code == CMD_READ_CONTROL) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // the NUM_PROTECTED - 1 codes just above the table are the memory readers that protection would block
   function automatic logic is_memory_read(input logic [7:0] code);
      logic above;
      logic below;
      above = code > CMD_READ_CONTROL;
      below = code < 8'(CMD_READ_CONTROL + NUM_PROTECTED);
      return above && below;
   endfunction

   // one decode of the control write serves the flag and the control byte
   function automatic logic is_control_write(input logic taken, input logic [7:0] code);
      return taken && (code == CMD_WRITE_CONTROL);
   endfunction

   // ----------------------------------------
   // control byte helpers
   // ----------------------------------------
   // protected write cannot clear
   function automatic logic written_flag(input logic current, input logic [7:0] data, input logic guarded);
      logic result;
      result = data[CTRL_DEBUG_MODE_BIT];
      if (guarded) begin
         result = current | data[CTRL_DEBUG_MODE_BIT];
      end
      return result;
   endfunction

   // the flag lands in its own field and every other bit is kept as given
   function automatic logic [7:0] compose_control(input logic flag, input logic [7:0] rest);
      logic [7:0] result;
      result = rest;
      result[CTRL_DEBUG_MODE_BIT] = flag;
      return result;
   endfunction

   // ----------------------------------------
   // acceptance
   // ----------------------------------------
   logic allowed;
   logic normal_ok;
   logic debug_ok;
   logic blocked_by_protect;
   logic control_write;
   logic breakpoint_return;
   logic next_flag;
   verdict_t verdict;

   assign blocked_by_protect = read_protect_option && is_memory_read(cmd_byte);
   assign debug_ok = is_defined(cmd_byte) && !blocked_by_protect;
   assign normal_ok = is_normal_subset(cmd_byte);

   always_comb begin
      allowed = 1'b0;
      if (cmd_valid) begin
         if (debug_mode_flag) begin
            allowed = debug_ok;
         end else begin
            allowed = normal_ok;
         end
      end
   end

   // one-hot verdict keeps accept and reject apart by construction
   always_comb begin
      if (!cmd_valid) begin
         verdict = VERDICT_IDLE;
      end else if (allowed) begin
         verdict = VERDICT_TAKEN;
      end else begin
         verdict = VERDICT_DROPPED;
      end
   end

   assign cmd_accept = (verdict == VERDICT_TAKEN);
   assign cmd_reject = (verdict == VERDICT_DROPPED);
   assign control_write = is_control_write(cmd_accept, cmd_byte);

   // ----------------------------------------
   // breakpoint tracking
   // ----------------------------------------
   // breakpoint opcode decode
   assign breakpoint_instruction = fetch_valid && (fetch_opcode == BREAKPOINT_OPCODE);

   assign breakpoint_return = irq_return && breakpoint_loop && breakpoint_instruction;

   // the loop is remembered so an interrupt return lands back on it
   // limitation: the mark only clears on entry to debug mode
   // or on reset, so a core leaving the loop by other means keeps it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         breakpoint_loop <= 1'b0;
      end else if (debug_mode_flag) begin
         breakpoint_loop <= 1'b0;
      end else if (breakpoint_instruction) begin
         breakpoint_loop <= 1'b1;
      end
   end

   // ----------------------------------------
   // debug mode flag
   // ----------------------------------------
   always_comb begin
      next_flag = debug_mode_flag;
      if (control_write) begin
         next_flag = written_flag(debug_mode_flag, cmd_data, read_protect_option);
      end
      // breakpoint entry sets flag
      // the entry event wins over a clear written in the same cycle
      if (breakpoint_return) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         debug_mode_flag <= CTRL_RESET_VALUE[CTRL_DEBUG_MODE_BIT];
      end else begin
         debug_mode_flag <= next_flag;
      end
   end

   // ----------------------------------------
   // control byte
   // ----------------------------------------
   // the flag field mirrors the mode so a read of the byte shows it
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         control_reg <= CTRL_RESET_VALUE;
      end else if (control_write) begin
         control_reg <= compose_control(next_flag, cmd_data);
      end else begin
         control_reg <= compose_control(next_flag, control_reg);
      end
   end

   // ----------------------------------------
   // last honoured command
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         accepted_cmd <= ACCEPTED_RESET_VALUE;
      end else if (cmd_accept) begin
         accepted_cmd <= cmd_byte;
      end
   end
endmodule // debug_command_gate

// ### debug_command_gate_properties.sv
// port assertions for the debug command gate
module gate_props (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic cmd_valid, // command byte strobe
   input wire logic [7:0] cmd_byte, // command byte
   input wire logic [7:0] cmd_data, // control write data
   input wire logic read_protect_option, // protection programmed
   input wire logic [7:0] fetch_opcode, // core opcode
   input wire logic fetch_valid, // opcode valid
   input wire logic irq_return, // interrupt return
   input wire logic cmd_accept, // honoured pulse
   input wire logic cmd_reject, // discarded pulse
   input wire logic [7:0] accepted_cmd, // last honoured code
   input wire logic [7:0] control_reg, // control byte
   input wire logic debug_mode_flag, // debug mode
   input wire logic breakpoint_instruction, // breakpoint decode
   input wire logic breakpoint_loop // looping on breakpoint
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   chk_one_verdict: assert property (cmd_valid |-> cmd_accept != cmd_reject)
      else $error("verdict not single");
   chk_idle_quiet: assert property (!cmd_valid |-> !cmd_accept && !cmd_reject)
      else $error("verdict without byte");
   chk_normal_subset: assert property (cmd_valid && !debug_mode_flag |-> cmd_accept == (cmd_byte inside {0,2,4,5}))
      else $error("normal subset wrong");
   chk_debug_all: assert property (cmd_valid && debug_mode_flag |-> cmd_accept == (cmd_byte inside {[0:5]} && cmd_byte != 1))
      else $error("debug set wrong");
   chk_last_cmd: assert property (cmd_accept |=> accepted_cmd == $past(cmd_byte))
      else $error("last command wrong");
   chk_protect_keep: assert property (cmd_accept && cmd_byte == 4 && read_protect_option && debug_mode_flag |=> debug_mode_flag)
      else $error("protected write cleared flag");
   chk_reject_quiet: assert property (cmd_reject && !irq_return |=> $stable(control_reg) && $stable(accepted_cmd))
      else $error("reject changed state");
   chk_write_lands: assert property (cmd_accept && cmd_byte == 8'h04 && !read_protect_option && !irq_return |=> control_reg == $past(cmd_data))
      else $error("control write lost");
   chk_loop_clear: assert property (debug_mode_flag |=> !breakpoint_loop)
      else $error("loop mark kept in debug");
   chk_bp_decode: assert property (breakpoint_instruction == (fetch_valid && fetch_opcode == 8'h00))
      else $error("breakpoint decode wrong");
   chk_bp_entry: assert property (breakpoint_loop && irq_return && breakpoint_instruction |=> debug_mode_flag)
      else $error("no debug entry");
endmodule // gate_props
bind debug_command_gate gate_props gate_props_inst (
   .core_clk(core_clk),
   .reset_n(reset_n),
   .cmd_valid(cmd_valid),
   .cmd_byte(cmd_byte),
   .cmd_data(cmd_data),
   .read_protect_option(read_protect_option),
   .fetch_opcode(fetch_opcode),
   .fetch_valid(fetch_valid),
   .irq_return(irq_return),
   .cmd_accept(cmd_accept),
   .cmd_reject(cmd_reject),
   .accepted_cmd(accepted_cmd),
   .control_reg(control_reg),
   .debug_mode_flag(debug_mode_flag),
   .breakpoint_instruction(breakpoint_instruction),
   .breakpoint_loop(breakpoint_loop)
);

// ### debug_gate_pkg.sv
// constants for the debug command gate
package debug_gate_pkg;
   // ----------------------------------------
   // command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_READ_REVISION = 8'h00;
   localparam logic [7:0] CMD_READ_STATUS = 8'h02;
   localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
   localparam logic [7:0] CMD_WRITE_CONTROL = 8'h04;
   localparam logic [7:0] CMD_READ_CONTROL = 8'h05;
   localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;
   // ----------------------------------------
   // control byte fields
   // ----------------------------------------
   localparam int CTRL_DEBUG_MODE_BIT = 7;
   localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
   localparam logic [7:0] ACCEPTED_RESET_VALUE = 8'h00;
   // ----------------------------------------
   // verdict codes
   // ----------------------------------------
   typedef enum logic [2:0] {
      VERDICT_IDLE = 3'b001,
      VERDICT_TAKEN = 3'b010,
      VERDICT_DROPPED = 3'b100
   } verdict_t;
endpackage

// ### debug_host.sv
// external debug host sending command bytes
module debug_host(
   input wire logic core_clk, // clock
   input wire logic go, // send one byte
   input wire logic [7:0] code, // command to send
   input wire logic [7:0] data, // control data
   output logic cmd_valid, // byte strobe
   output logic [7:0] cmd_byte, // byte lines
   output logic [7:0] cmd_data); // data lines
   timeunit 1ns;
   timeprecision 1ps;
   // start the idle lines at a known value so the churn is not stuck unknown
   initial begin
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      cmd_data = 8'h00;
   end
   // one byte a frame, lines churn when idle
   always @(posedge core_clk) begin
      cmd_valid <= go;
      cmd_byte <= go ? code : ~cmd_byte;
      cmd_data <= go ? data : ~cmd_data;
   end
endmodule // debug_host

// ### tb.sv
// testbench for the debug command gate
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, reset_n = 0, go = 0, rp = 0, fv = 0, irq = 0, cmd_valid, ca, cr, dm, bi, bl;
   logic [7:0] code = 0, data = 0, op = 0, cb, cd, ac, ctl, last = 0;
   logic [7:0] codes[9] = '{0, 1, 2, 3, 4, 5, 6, 8'h0d, 8'hff};
   int errors = 0, n_checks = 0, cyc = 0;
   initial forever #2.5 core_clk = ~core_clk;
   debug_host debug_host_inst(.core_clk, .go, .code, .data, .cmd_valid, .cmd_byte(cb), .cmd_data(cd));
   debug_command_gate debug_command_gate_inst(.core_clk, .reset_n, .cmd_valid, .cmd_byte(cb), .cmd_data(cd),
      .read_protect_option(rp), .fetch_opcode(op), .fetch_valid(fv), .irq_return(irq), .cmd_accept(ca),
      .cmd_reject(cr), .accepted_cmd(ac), .control_reg(ctl), .debug_mode_flag(dm),
      .breakpoint_instruction(bi), .breakpoint_loop(bl));
   task automatic check(input string n, input logic [7:0] e, g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic send(input logic [7:0] c, d, input logic acc);
      @(posedge core_clk) go <= 1;
      code <= c;
      data <= d;
      @(posedge core_clk) go <= 0;
      #1 check("accept", {7'b0, acc}, {7'b0, ca});
      check("reject", {7'b0, !acc}, {7'b0, cr});
      @(posedge core_clk);
      #1 if (acc) last = c;
   endtask
   task automatic run_table(input logic dbg);
      foreach (codes[i]) begin
         send(codes[i], {dbg, 7'b0}, dbg ? codes[i] inside {0, 2, 3, 4, 5} : codes[i] inside {0, 2, 4, 5});
         check("last", last, ac);
         check("flag", {7'b0, dbg}, {7'b0, dm});
      end
   endtask
   task automatic t_normal();
      check("ctl", 8'h00, ctl);
      run_table(0);
   endtask
   task automatic t_debug();
      send(8'h04, 8'h80, 1);
      check("ctl", 8'h80, ctl);
      run_table(1);
   endtask
   task automatic t_protect();
      @(posedge core_clk) rp <= 1;
      send(8'h04, 8'h00, 1);
      check("held", 8'h80, ctl);
      run_table(1);
      @(posedge core_clk) rp <= 0;
      send(8'h04, 8'h00, 1);
      check("cleared", 8'h00, ctl);
   endtask
   task automatic t_break();
      @(posedge core_clk) fv <= 1;
      #1 check("brk", 8'h01, {7'b0, bi});
      send(8'h03, 8'h00, 0);
      check("loop", 8'h01, {7'b0, bl});
      @(posedge core_clk) irq <= 1;
      @(posedge core_clk) irq <= 0;
      #1 check("entry", 8'h01, {7'b0, dm});
      @(posedge core_clk);
      #1 check("left", 8'h00, {7'b0, bl});
   endtask
   task automatic t_reset();
      @(posedge core_clk) reset_n <= 0;
      fv <= 0;
      #1 check("rst flag", 8'h00, {7'b0, dm});
      check("rst ctl", 8'h00, ctl);
      check("rst last", 8'h00, ac);
      check("rst loop", 8'h00, {7'b0, bl});
      repeat (2) @(posedge core_clk);
      reset_n <= 1;
      send(8'h02, 8'h00, 1);
      check("last", 8'h02, ac);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge core_clk) if (++cyc == 3000) begin
      errors++;
      wrap_up();
   end
   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1;
      t_normal();
      t_debug();
      t_protect();
      t_break();
      t_reset();
      wrap_up();
   end
endmodule // tb
